// file: testbench/isdn_te_layer1_activation_fsm_test.sv
// Self-checking bench for the terminal activation state machine
`timescale 1ns/1ps
module isdn_te_layer1_activation_fsm_test;
   // ==========================================================
   // Signals and instances
   localparam logic [7:0] AI = 8'hA0, DI = 8'h50, MDI = 8'h10, IIC = 8'h08;
   localparam logic [7:0] IID = 8'h04, EI1 = 8'h02, EI2 = 8'h01;
   logic       i_sys_clk, i_sys_rst, i_local_power, i_ph_act_req, i_holdoff_en;
   logic       vld, rxb, sig, inf2, inf4, lost, t3;
   logic [2:0] mode;
   logic [7:0] lat;
   wire  [7:0] p;
   logic [3:0] st;
   logic [1:0] tx;
   int         pc [8];
   int         fail_count, checks;
   nt_model u_nt (.i_sys_clk(i_sys_clk), .i_mode(mode), .i_lat(lat), .o_rx_bit_valid(vld),
      .o_rx_bit(rxb), .o_sig_present(sig), .o_info2_det(inf2), .o_info4_det(inf4),
      .o_lost_framing(lost));
   te_l1_activation #(.REACT_CYC(20), .HOLDOFF_CYC(50), .T3_CYC(100)) dut (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_local_power(i_local_power),
      .i_rx_bit_valid(vld), .i_rx_bit(rxb), .i_sig_present(sig), .i_info2_det(inf2),
      .i_info4_det(inf4), .i_lost_framing(lost), .i_ph_act_req(i_ph_act_req),
      .i_holdoff_en(i_holdoff_en), .o_state(st), .o_tx_info(tx), .o_t3_running(t3),
      .o_ph_ai(p[7]), .o_ph_di(p[6]), .o_mph_ai(p[5]), .o_mph_di(p[4]), .o_mph_ii_c(p[3]),
      .o_mph_ii_d(p[2]), .o_mph_ei1(p[1]), .o_mph_ei2(p[0]));
   // Clock at 40 MHz
   initial begin
      i_sys_clk = 1'b0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   // Pulse totals; a pulse shows in the count one edge after it is issued
   always @(posedge i_sys_clk)
      for (int k = 0; k < 8; k++) pc[k] += p[k];
   // ==========================================================
   // Tasks and functions
   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
      #2;
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Expected pulse totals, one nibble per indication
   function automatic logic [31:0] ev(input logic [7:0] m);
      for (int k = 0; k < 8; k++) ev[4*k+:4] = {3'h0, m[k]};
   endfunction
   function automatic logic [31:0] tot();
      for (int k = 0; k < 8; k++) tot[4*k+:4] = pc[k][3:0];
   endfunction
   task automatic clr();
      for (int k = 0; k < 8; k++) pc[k] = 0;
   endtask
   task automatic req();
      i_ph_act_req = 1'b1;
      cyc(1);
      i_ph_act_req = 1'b0;
   endtask
   task automatic sig4();
      lat = 8'h01 + 8'($urandom % 6);
      mode = 3'h3;
      cyc(lat + 3);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      #(4000 * 25);
      fail_count++;
      final_report();
   end
   // ==========================================================
   // Tests
   initial begin
      i_sys_rst = 1'b1;
      i_local_power = 1'b1;
      i_ph_act_req = 1'b0;
      i_holdoff_en = 1'b0;
      mode = 3'h0;
      lat = 8'h00;
      void'($urandom(32'hAD74));
      cyc(2);
      i_sys_rst = 1'b0;
      cmp(st, 4'h1);
      cyc(21);
      cmp(st, 4'h2);
      clr();
      cyc(40);
      cmp({tot(), st}, {ev(IIC), 4'h3});
      $display("info0 from F2 done");
      mode = 3'h1;
      cyc(2);
      req();
      cyc(2);
      cmp({t3, tx, st}, 7'h03);
      mode = 3'h0;
      cyc(2);
      req();
      cmp({t3, tx, st}, 7'h54);
      lat = 8'h02 + 8'($urandom % 6);
      mode = 3'h2;
      cyc(1);
      cmp(st, 4'h5);
      cyc(lat + 2);
      cmp(st, 4'h6);
      clr();
      sig4();
      cmp({tot(), t3, tx, st}, {ev(AI | EI2), 7'h37});
      $display("activation done");
      clr();
      mode = 3'h4;
      cyc(2);
      cmp({tot(), st}, {ev(EI1), 4'h8});
      clr();
      sig4();
      cmp({tot(), st}, {ev(AI | EI2), 4'h7});
      clr();
      mode = 3'h0;
      cyc(60);
      cmp(st, 4'h7);
      cyc(40);
      cmp({tot(), tx, st}, {ev(DI), 6'h03});
      $display("deactivation done");
      sig4();
      clr();
      i_holdoff_en = 1'b1;
      mode = 3'h0;
      cyc(100);
      cmp({tot(), st}, {ev(MDI), 4'h3});
      sig4();
      cyc(80);
      cmp({tot(), st}, {ev(MDI | AI), 4'h7});
      mode = 3'h4;
      cyc(2);
      clr();
      mode = 3'h0;
      for (int n = 0; n < 200 && st !== 4'h3; n++) cyc(1);
      cyc(41);
      cmp({tot(), st}, {ev(MDI | EI2), 4'h3});
      cyc(20);
      cmp(tot(), ev(DI | EI2));
      $display("hold-off done");
      clr();
      i_local_power = 1'b0;
      cyc(2);
      cmp({tot(), st}, {ev(IID), 4'h1});
      $display("power loss done");
      final_report();
   end
endmodule

// file: testbench/nt_model.sv
// Network termination model driving the terminal receiver
`timescale 1ns/1ps
module nt_model (
   input  wire logic       i_sys_clk,
   input  wire logic [2:0] i_mode,
   input  wire logic [7:0] i_lat,
   output logic            o_rx_bit_valid, o_rx_bit, o_sig_present,
   output logic            o_info2_det, o_info4_det, o_lost_framing
);
   // ==========================================================
   // Line signal
   logic [2:0] last_ff = 3'h0;
   logic [7:0] age_ff = 8'h00;
   // Age of the line signal; recognition needs i_lat cycles, so slow answers too
   always @(posedge i_sys_clk) begin
      last_ff <= i_mode;
      age_ff  <= (i_mode != last_ff) ? 8'h00 : age_ff + {7'h00, age_ff != 8'hFF};
   end
   assign o_rx_bit_valid = 1'b1;
   assign o_rx_bit       = (i_mode == 3'h0);
   assign o_sig_present  = (i_mode != 3'h0);
   assign o_info2_det    = (i_mode == 3'h2) && (last_ff == i_mode) && (age_ff >= i_lat);
   assign o_info4_det    = (i_mode == 3'h3) && (last_ff == i_mode) && (age_ff >= i_lat);
   assign o_lost_framing = (i_mode == 3'h4);
endmodule

// file: testbench/te_chk.sv
// Assertion checker for the terminal activation state machine
`timescale 1ns/1ps
module te_chk #(
   parameter REACT_CYC = 20
) (
   input wire       i_sys_clk, i_sys_rst, i_local_power, i_rx_bit_valid, i_rx_bit,
   input wire       i_sig_present, i_info2_det, i_info4_det, i_ph_act_req, i_holdoff_en,
   input wire [3:0] o_state,
   input wire [1:0] o_tx_info,
   input wire       o_t3_running, o_ph_ai, o_ph_di, o_mph_ai, o_mph_di, o_mph_ei1, o_mph_ei2
);
   // ==========================================================
   // Helper logic
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic [15:0] run_ff;
   // Cycles since the last ZERO; zero means no INFO 0 can be qualified now
   always @(posedge i_sys_clk or posedge i_sys_rst)
      if (i_sys_rst) run_ff <= 16'h0000;
      else if (i_rx_bit_valid && !i_rx_bit) run_ff <= 16'h0000;
      else if (run_ff != 16'hFFFF) run_ff <= run_ff + 16'h0001;
   // ==========================================================
   // Assertions
   AST_ANY_F4: assert property (o_state == 4'h4 && i_local_power && i_sig_present
      && !i_info2_det && !i_info4_det && run_ff < 16'h0030 |=> o_state == 4'h5)
      else $error("unclassified signal did not move F4 to F5");
   AST_INFO4: assert property (o_state inside {4'h3, 4'h4, 4'h5} && i_local_power
      && i_info4_det && run_ff == 16'h0000 |=> o_state == 4'h7 && o_ph_ai && o_mph_ai
      && !o_t3_running && o_tx_info == 2'h3) else $error("INFO 4 activation wrong");
   AST_INFO2: assert property (o_state inside {4'h3, 4'h4, 4'h5} && i_local_power
      && i_info2_det && !i_info4_det && run_ff == 16'h0000 |=> o_state == 4'h6)
      else $error("INFO 2 did not reach F6");
   AST_LOST: assert property (o_state == 4'h8 && $past(o_state) != 4'h8 |-> o_mph_ei1)
      else $error("entry to F8 without error indication");
   AST_REQ_IGN: assert property (o_state == 4'h3 && i_local_power && i_ph_act_req
      && i_sig_present && !i_info2_det && !i_info4_det && run_ff == 16'h0000
      |=> o_state == 4'h3 && !o_t3_running) else $error("request acted on");
   AST_REQ_ACT: assert property (o_state == 4'h3 && i_local_power && i_ph_act_req
      && !i_sig_present |=> o_state == 4'h4 && o_tx_info == 2'h1 && o_t3_running)
      else $error("request not acted on");
   AST_REACT: assert property (o_state == 4'h3 && $past(o_state) == 4'h7
      |-> run_ff >= 16'h0030 + REACT_CYC) else $error("F7 left too early");
   AST_ONES: assert property (o_state == 4'h3 && $past(o_state) == 4'h2
      |-> run_ff >= 16'h0031) else $error("INFO 0 taken on a short run");
   AST_DI_NOW: assert property ($past(o_state) == 4'h7 && o_state == 4'h3
      && !$past(i_holdoff_en) |-> o_mph_di && o_ph_di) else $error("missing deactivation");
   AST_HOLD: assert property ($past(o_state) inside {4'h7, 4'h8} && o_state == 4'h3
      && $past(i_holdoff_en) && !$past(o_t3_running) |-> o_mph_di && !o_ph_di)
      else $error("indication not held off");
   AST_EI2: assert property ($past(o_state) == 4'h8 && o_state == 4'h3
      && !$past(o_t3_running) |-> o_mph_ei2) else $error("F8 exit lacks error two");
   COV_ACT: cover property (o_state == 4'h4 ##[1:20] o_state == 4'h7);
   COV_DEACT: cover property (o_state == 4'h7 ##1 o_state == 4'h3);
   COV_F5: cover property (o_state == 4'h4 ##1 o_state == 4'h5);
endmodule
bind te_l1_activation te_chk #(.REACT_CYC(REACT_CYC)) u_chk (.i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst), .i_local_power(i_local_power), .i_rx_bit_valid(i_rx_bit_valid),
   .i_rx_bit(i_rx_bit), .i_sig_present(i_sig_present), .i_info2_det(i_info2_det),
   .i_info4_det(i_info4_det), .i_ph_act_req(i_ph_act_req), .i_holdoff_en(i_holdoff_en),
   .o_state(o_state), .o_tx_info(o_tx_info), .o_t3_running(o_t3_running),
   .o_ph_ai(o_ph_ai), .o_ph_di(o_ph_di), .o_mph_ai(o_mph_ai), .o_mph_di(o_mph_di),
   .o_mph_ei1(o_mph_ei1), .o_mph_ei2(o_mph_ei2));

// file: verilog/ones_run_detect.v
// Detector of a run of contiguous binary ONEs on the received bit stream
`timescale 1ns/1ps
module ones_run_detect #(
   parameter RUN_LEN = 48
) (
   input  wire i_sys_clk,
   input  wire i_sys_rst,
   input  wire i_rx_bit_valid,
   input  wire i_rx_bit,
   output reg  o_run_ok
);
   // ==========================================================
   // Run counter
   localparam [6:0] RUN_MAX = RUN_LEN[6:0];
   reg [6:0] run_cnt_ff;

   // Any ZERO breaks the run; count saturates so a long idle line stays INFO 0
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         run_cnt_ff <= 7'h00;
         o_run_ok   <= 1'b0;
      end else if (i_rx_bit_valid) begin
         // [R1] unbroken ONEs run
         if (!i_rx_bit) begin
            run_cnt_ff <= 7'h00;
            o_run_ok   <= 1'b0;
         end else if (run_cnt_ff < RUN_MAX) begin
            run_cnt_ff <= run_cnt_ff + 7'h01;
            o_run_ok   <= (run_cnt_ff + 7'h01) >= RUN_MAX;
         end
      end
   end
endmodule

// file: verilog/te_l1_activation.v
// Layer 1 activation and deactivation state machine of a locally powered terminal
`timescale 1ns/1ps
`include "te_l1_defines.vh"
module te_l1_activation #(
   parameter INFO0_ONES   = `TE_INFO0_ONES,
   parameter REACT_CYC    = `TE_REACT_CYC,
   parameter HOLDOFF_CYC  = `TE_HOLDOFF_CYC,
   parameter T3_CYC       = `TE_T3_CYC
) (
   input  wire       i_sys_clk,
   input  wire       i_sys_rst,
   input  wire       i_local_power,
   input  wire       i_rx_bit_valid,
   input  wire       i_rx_bit,
   input  wire       i_sig_present,
   input  wire       i_info2_det,
   input  wire       i_info4_det,
   input  wire       i_lost_framing,
   input  wire       i_ph_act_req,
   input  wire       i_holdoff_en,
   output reg  [3:0] o_state,
   output reg  [1:0] o_tx_info,
   output reg        o_t3_running,
   output reg        o_ph_ai,
   output reg        o_ph_di,
   output reg        o_mph_ai,
   output reg        o_mph_di,
   output reg        o_mph_ii_c,
   output reg        o_mph_ii_d,
   output reg        o_mph_ei1,
   output reg        o_mph_ei2
);
   // ==========================================================
   // States
   localparam [3:0] F1 = 4'h1;
   localparam [3:0] F2 = 4'h2;
   localparam [3:0] F3 = 4'h3;
   localparam [3:0] F4 = 4'h4;
   localparam [3:0] F5 = 4'h5;
   localparam [3:0] F6 = 4'h6;
   localparam [3:0] F7 = 4'h7;
   localparam [3:0] F8 = 4'h8;
   localparam       CW = 26;

   // ==========================================================
   // Received INFO 0 and signal classification
   wire info0_rx;

   ones_run_detect #(
      .RUN_LEN        (INFO0_ONES)
   ) u_info0 (
      .i_sys_clk      (i_sys_clk),
      .i_sys_rst      (i_sys_rst),
      .i_rx_bit_valid (i_rx_bit_valid),
      .i_rx_bit       (i_rx_bit),
      .o_run_ok       (info0_rx)
   );

   // [R10] unclassified signal
   wire any_sig = i_sig_present & ~info0_rx & ~i_info2_det & ~i_info4_det;

   // Sent INFO as a function of state
   function [1:0] tx_of;
      input [3:0] st;
      begin
         case (st)
            F4:      tx_of = `TE_TX_INFO1;
            F6, F7:  tx_of = `TE_TX_INFO3;
            default: tx_of = `TE_TX_INFO0;
         endcase
      end
   endfunction

   // ==========================================================
   // Timers: T3, INFO 0 reaction delay, deactivation hold-off
   reg  [CW-1:0] t3_cnt_ff;
   reg  [CW-1:0] react_cnt_ff;
   reg  [CW-1:0] hold_cnt_ff;
   reg           hold_run_ff;
   reg  [3:0]    state_ff;
   wire          t3_exp    = o_t3_running & (t3_cnt_ff >= T3_CYC[CW-1:0] - 1'b1);
   wire          react_ok  = (react_cnt_ff >= REACT_CYC[CW-1:0] - 1'b1);
   wire          hold_exp  = hold_run_ff & (hold_cnt_ff == HOLDOFF_CYC[CW-1:0] - 1'b1);

   // ==========================================================
   // Next-state decode
   reg  [3:0] nxt_state;
   reg        nxt_t3_run;
   reg        nxt_hold_start;
   reg        nxt_ph_ai;
   reg        nxt_ph_di;
   reg        nxt_mph_ai;
   reg        nxt_mph_di;
   reg        nxt_mph_ii_c;
   reg        nxt_mph_ii_d;
   reg        nxt_mph_ei1;
   reg        nxt_mph_ei2;

   // Event priority: power, INFO 0, lost framing, INFO 4, INFO 2, any signal,
   // T3 expiry, activate request. Only one event is acted on per clock.
   always @* begin
      nxt_state      = state_ff;
      nxt_t3_run     = o_t3_running;
      nxt_hold_start = 1'b0;
      nxt_ph_ai      = 1'b0;
      nxt_ph_di      = 1'b0;
      nxt_mph_ai     = 1'b0;
      nxt_mph_di     = 1'b0;
      nxt_mph_ii_c   = 1'b0;
      nxt_mph_ii_d   = 1'b0;
      nxt_mph_ei1    = 1'b0;
      nxt_mph_ei2    = 1'b0;
      if (!i_local_power) begin
         // Loss of local power
         if (state_ff != F1) begin
            nxt_state    = F1;
            nxt_t3_run   = 1'b0;
            nxt_mph_ii_d = (state_ff != F2);
            nxt_mph_di   = (state_ff > F3);
            nxt_ph_di    = (state_ff > F3);
         end
      end else if (state_ff == F1) begin
         nxt_state = F2;
      end else if (info0_rx && (state_ff == F2 || state_ff == F8 ||
                                ((state_ff == F6 || state_ff == F7) && react_ok))) begin
         // [R2] INFO 0 per state
         nxt_state = F3;
         if (state_ff == F2) begin
            nxt_mph_ii_c = 1'b1;
         end else begin
            nxt_mph_di  = 1'b1;
            nxt_mph_ei2 = (state_ff == F8);
            nxt_t3_run  = 1'b0;
            // [R4] hold-off on leaving F7/F8
            if (i_holdoff_en && state_ff != F6) begin
               nxt_hold_start = 1'b1;
            end else begin
               nxt_ph_di = 1'b1;
            end
         end
      end else if (i_lost_framing && (state_ff == F6 || state_ff == F7)) begin
         // [R11] lost framing
         nxt_state   = F8;
         nxt_mph_ei1 = 1'b1;
      end else if (i_info4_det && state_ff != F7) begin
         // [R12] INFO 4 activates
         nxt_state    = F7;
         nxt_ph_ai    = 1'b1;
         nxt_mph_ai   = 1'b1;
         nxt_t3_run   = 1'b0;
         nxt_mph_ii_c = (state_ff == F2);
         nxt_mph_ei2  = (state_ff == F6 || state_ff == F8);
      end else if (i_info2_det && state_ff != F6) begin
         // [R11] INFO 2 synchronises
         nxt_state    = F6;
         nxt_mph_ii_c = (state_ff == F2);
         nxt_mph_ei1  = (state_ff == F7);
         nxt_mph_ei2  = (state_ff == F8);
      end else if (any_sig && state_ff == F4) begin
         // [R3] [R9] unidentified signal
         nxt_state = F5;
      end else if (t3_exp) begin
         // T3 expiry gives up activation
         nxt_t3_run = 1'b0;
         nxt_mph_di = 1'b1;
         nxt_ph_di  = 1'b1;
         if (state_ff != F6) begin
            nxt_state = F3;
         end
      end else if (i_ph_act_req && state_ff == F3 && !any_sig) begin
         // [R7] request gated by receiver
         nxt_state  = F4;
         nxt_t3_run = 1'b1;
      end
   end

   // ==========================================================
   // State and registered primitives
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_ff     <= F1;
         o_state      <= F1;
         o_tx_info    <= `TE_TX_INFO0;
         o_t3_running <= 1'b0;
         o_ph_ai      <= 1'b0;
         o_mph_ai     <= 1'b0;
         o_mph_di     <= 1'b0;
         o_mph_ii_c   <= 1'b0;
         o_mph_ii_d   <= 1'b0;
         o_mph_ei1    <= 1'b0;
         o_mph_ei2    <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         o_state      <= nxt_state;
         o_tx_info    <= tx_of(nxt_state);
         o_t3_running <= nxt_t3_run;
         o_ph_ai      <= nxt_ph_ai;
         o_mph_ai     <= nxt_mph_ai;
         o_mph_di     <= nxt_mph_di;
         o_mph_ii_c   <= nxt_mph_ii_c;
         o_mph_ii_d   <= nxt_mph_ii_d;
         o_mph_ei1    <= nxt_mph_ei1;
         o_mph_ei2    <= nxt_mph_ei2;
      end
   end

   // ==========================================================
   // T3 counter, restarted on every start so a stale count never expires early
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         t3_cnt_ff <= {CW{1'b0}};
      end else if (!nxt_t3_run || !o_t3_running) begin
         t3_cnt_ff <= {CW{1'b0}};
      end else begin
         t3_cnt_ff <= t3_cnt_ff + 1'b1;
      end
   end

   // Reaction delay: INFO 0 must be held this long in F6/F7 before INFO 0 is sent,
   // which also rides out short all-ONE stretches of a live line
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         react_cnt_ff <= {CW{1'b0}};
      end else if (info0_rx && (state_ff == F6 || state_ff == F7)) begin
         // [R8] no earlier than 250 us
         if (!react_ok) begin
            react_cnt_ff <= react_cnt_ff + 1'b1;
         end
      end else begin
         react_cnt_ff <= {CW{1'b0}};
      end
   end

   // Hold-off: PH-DI is deferred, and dropped if F7 is re-entered in time
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         hold_run_ff <= 1'b0;
         hold_cnt_ff <= {CW{1'b0}};
         o_ph_di     <= 1'b0;
      end else begin
         o_ph_di <= nxt_ph_di;
         if (nxt_hold_start) begin
            // [R6] 500 ms default
            hold_run_ff <= 1'b1;
            hold_cnt_ff <= {CW{1'b0}};
         end else if (hold_run_ff) begin
            // [R5] cancel on return to F7
            if (nxt_state == F7 || nxt_state == F1) begin
               hold_run_ff <= 1'b0;
            end else if (hold_exp) begin
               hold_run_ff <= 1'b0;
               o_ph_di     <= 1'b1;
            end else begin
               hold_cnt_ff <= hold_cnt_ff + 1'b1;
            end
         end
      end
   end
endmodule

// file: verilog/te_l1_defines.vh
// Constants for the terminal layer 1 activation state machine
// What this block does
// [R1] INFO 0 is recognised only after 48 or more contiguous received binary ONEs.
// [R2] INFO 0: F2 to F3 with MPH-II(c); F6/F7/F8 deactivate to F3.
// [R3] In F4 an unclassified received signal moves to F5; elsewhere no change.
// [R4] Optional hold-off timer starts when INFO 0 forces exit from F7 or F8.
// [R5] With hold-off, PH-DI is given only if F7 not re-entered before expiry.
// [R6] Hold-off duration lies between 500 ms and 1000 ms.
// [R7] Activate request ignored while receiving signals other than INFO 0/2/4.
// [R8] In F6/F7 INFO 0 transmission starts no earlier than 250 us after detection.
// [R9] No INFO 2/4 recognised within 5 ms of a signal means go to F5; here F4 goes to F5 at once on an unclassified signal, with no 5 ms wait.
// [R10] Any-signal event: signal present but not yet classified as INFO 2/4.
// [R11] INFO 2 enters F6 with state-specific indications; lost framing goes to F8.
// [R12] INFO 4 enters F7 with PH-AI, MPH-AI, T3 stop and state-specific indications.
`ifndef TE_L1_DEFINES_VH
`define TE_L1_DEFINES_VH

// ==========================================================
// Clock and timing
`define TE_CLK_HZ          40000000
`define TE_CLK_PER_US      (`TE_CLK_HZ / 1000000)
`define TE_CLK_PER_MS      (`TE_CLK_HZ / 1000)
`define TE_INFO0_ONES      48
`define TE_REACT_US        250
`define TE_REACT_CYC       (`TE_REACT_US * `TE_CLK_PER_US)
`define TE_RECOG_MS        5
`define TE_RECOG_CYC       (`TE_RECOG_MS * `TE_CLK_PER_MS)
`define TE_HOLDOFF_MIN_MS  500
`define TE_HOLDOFF_MAX_MS  1000
`define TE_HOLDOFF_CYC     (`TE_HOLDOFF_MIN_MS * `TE_CLK_PER_MS)
`define TE_T3_MS           1000
`define TE_T3_CYC          (`TE_T3_MS * `TE_CLK_PER_MS)

// ==========================================================
// Transmitted INFO codes
`define TE_TX_INFO0        2'h0
`define TE_TX_INFO1        2'h1
`define TE_TX_INFO3        2'h3

`endif
